// ---- dv/irab_assertions.sv ----
// Port checker for the indirect register access bridge
`timescale 1ns/1ps
module irab_assertions (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic hsel_in,
    input wire logic [1:0] htrans_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic [2:0] analog_target_select_out,
    input wire logic [7:0] indirect_offset_out,
    input wire logic ana_req_out,
    input wire logic ana_write_out,
    input wire logic ana_ack_in,
    input wire logic [7:0] ana_rdata_in,
    input wire logic [1:0] bridge_target_out,
    input wire logic psel_out,
    input wire logic penable_out,
    input wire logic pwrite_out,
    input wire logic [15:0] paddr_out,
    input wire logic pready_in
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);
    ////////////////////////////////////////
    sequence s_setup; psel_out && !penable_out; endsequence
    sequence s_stall; psel_out && penable_out && !pready_in; endsequence
    property p_setup_access; s_setup |=> psel_out && penable_out; endproperty
    property p_hold; s_stall |=> psel_out && $stable(paddr_out) && $stable(pwrite_out); endproperty
    property p_end; psel_out && penable_out && pready_in |=> !psel_out && !penable_out; endproperty
    property p_ro; psel_out && pwrite_out |-> !bridge_target_out[1]; endproperty
    property p_ana_sel; ana_req_out |-> analog_target_select_out inside {3'h4, 3'h5}; endproperty
    property p_ana_hold;
        ana_req_out && !ana_ack_in |=> ana_req_out && $stable(indirect_offset_out) && $stable(ana_write_out);
    endproperty
    property p_ana_rd;
        ana_req_out && ana_ack_in && !ana_write_out |=>
            hreadyout_out && !ana_req_out && hrdata_out == {24'h00, $past(ana_rdata_in)};
    endproperty
    property p_wait; hsel_in && hready_in && htrans_in == 2'h2 |=> !hreadyout_out; endproperty
    property p_okay; hresp_out == 1'b0 && hrdata_out[31:8] == 24'h00; endproperty
    a_setup_access: assert property (p_setup_access) else $error("no access phase");
    a_hold: assert property (p_hold) else $error("address moved in wait");
    a_end: assert property (p_end) else $error("transfer not closed");
    a_ro: assert property (p_ro) else $error("write to read-only target");
    a_ana_sel: assert property (p_ana_sel) else $error("analog request to bad target");
    a_ana_hold: assert property (p_ana_hold) else $error("analog request unstable");
    a_ana_rd: assert property (p_ana_rd) else $error("analog read data lost");
    a_wait: assert property (p_wait) else $error("no wait state");
    a_okay: assert property (p_okay) else $error("bad response or data");
endmodule
bind irab_bridge irab_assertions chk (.*);

// ---- dv/irab_far_model.sv ----
// Far-side model: APB register blocks and analog register targets
`timescale 1ns/1ps
module irab_far_model (
    input wire logic core_clk_in,
    input wire logic [2:0] analog_target_select_in,
    input wire logic [7:0] indirect_offset_in,
    input wire logic [7:0] indirect_data_value_in,
    input wire logic ana_req_in,
    input wire logic ana_write_in,
    output logic ana_ack_out,
    output logic [7:0] ana_rdata_out,
    input wire logic [1:0] bridge_target_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [15:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    input wire logic [3:0] wait_in
);
    logic [7:0] amem [512];
    logic [31:0] pmem [256];
    logic [3:0] acnt = 4'h0;
    logic [3:0] pcnt = 4'h0;
    logic junk = 1'b0;
    logic [8:0] aidx;
    logic [7:0] pidx;
    ////////////////////////////////////////
    assign aidx = {analog_target_select_in[0], indirect_offset_in};
    assign pidx = {bridge_target_in, paddr_in[8], paddr_in[4:0]};
    assign ana_ack_out = ana_req_in && acnt == wait_in;
    // Released lines toggle so stale data never looks valid
    assign ana_rdata_out = ana_ack_out ? amem[aidx] : {8{junk}};
    assign pready_out = psel_in && penable_in && pcnt == wait_in;
    assign prdata_out = pready_out ? pmem[pidx] : {32{junk}};
    initial begin
        for (int i = 0; i < 512; i++) amem[i] = 8'(i) ^ 8'h5a;
        for (int i = 0; i < 256; i++) pmem[i] = {8'hc3, 8'(i), 8'h96, ~8'(i)};
    end
    always @(posedge core_clk_in) begin
        junk <= ~junk;
        acnt <= (ana_req_in && !ana_ack_out) ? acnt + 4'h1 : 4'h0;
        pcnt <= (psel_in && penable_in && !pready_out) ? pcnt + 4'h1 : 4'h0;
        if (ana_ack_out && ana_write_in) amem[aidx] <= indirect_data_value_in;
        if (pready_out && pwrite_in) pmem[pidx] <= pwdata_in;
    end
endmodule

// ---- dv/test_indirect_register_access_bridge.sv ----
// Self-checking bench of the indirect register access bridge
`timescale 1ns/1ps
module test_indirect_register_access_bridge;
    logic core_clk, rst_b, hsel, hwrite, hreadyout, hresp, ana_req, ana_write, ana_ack, psel, penable, pwrite, pready;
    logic [31:0] haddr, hwdata, hrdata, pwdata, prdata, rd;
    logic [1:0] htrans, br_tgt;
    logic [2:0] hsize, ana_sel;
    logic [7:0] ana_off, ana_data, ana_rdata;
    logic [15:0] paddr;
    logic [3:0] wait_cycles;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    int xfers = 0;
    irab_bridge dut (.core_clk_in(core_clk), .rst_b_in(rst_b), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout),
        .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp), .analog_target_select_out(ana_sel),
        .indirect_offset_out(ana_off), .indirect_data_value_out(ana_data), .ana_req_out(ana_req),
        .ana_write_out(ana_write), .ana_ack_in(ana_ack), .ana_rdata_in(ana_rdata), .bridge_target_out(br_tgt),
        .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
        .prdata_in(prdata), .pready_in(pready));
    irab_far_model far (.core_clk_in(core_clk), .analog_target_select_in(ana_sel), .indirect_offset_in(ana_off),
        .indirect_data_value_in(ana_data), .ana_req_in(ana_req), .ana_write_in(ana_write), .ana_ack_out(ana_ack),
        .ana_rdata_out(ana_rdata), .bridge_target_in(br_tgt), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .wait_in(wait_cycles));
    ////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (psel && penable && pready) xfers++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end
    task automatic conclude;
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Address phase held until ready, then data phase held until ready again
    task automatic ahb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        ahb(1'b1, idx, wd);
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        ahb(1'b0, idx, 8'h00);
        chk(rd, {24'h0, exp});
    endtask
    ////////////////////////////////////////
    task automatic t_reset_map;
        for (int i = 8'h40; i <= 8'h4e; i++) rdchk(8'(i), 8'h00);
        wr(8'h44, 8'hff);
        rdchk(8'h44, 8'h00);
        wr(8'h40, 8'hff);
        rdchk(8'h40, 8'h1f);
        $display("test reset_map done");
    endtask
    task automatic t_analog;
        for (int s = 4; s <= 5; s++) begin
            wait_cycles <= (s == 4) ? 4'h0 : 4'h3;
            wr(8'h40, {3'h0, 3'(s), 2'b10});
            wr(8'h41, 8'h10);
            wr(8'h42, 8'(8'ha0 + s));
            wr(8'h42, 8'(8'hb0 + s));
            chk({24'h0, far.amem[{s[0], 8'h10}]}, 32'(8'ha0 + s));
            rdchk(8'h41, 8'h12);
            wr(8'h40, {3'h0, 3'(s), 2'b01});
            wr(8'h41, 8'h11);
            rdchk(8'h42, 8'(8'hb0 + s));
            rdchk(8'h41, 8'h11);
            wr(8'h40, {3'h0, 3'(s), 2'b11});
            rdchk(8'h42, 8'(8'hb0 + s));
            rdchk(8'h41, 8'h12);
        end
        wr(8'h40, 8'h02);
        wr(8'h41, 8'h20);
        wr(8'h42, 8'h77);
        rdchk(8'h41, 8'h20);
        chk({24'h0, far.amem[9'h020]}, 32'h7a);
        $display("test analog done");
    endtask
    task automatic t_bridge_read;
        logic [7:0] idx;
        logic [31:0] exp;
        for (int t = 0; t < 4; t++) begin
            wait_cycles <= 4'(t);
            wr(8'h49, 8'h0c);
            wr(8'h4a, 8'h01);
            wr(8'h48, {3'h0, 2'(t), 3'b111});
            do ahb(1'b0, 8'h48, 8'h00); while (rd[1] !== 1'b0);
            chk(rd, {27'h0, 2'(t), 3'b101});
            idx = {2'(t), 6'h2c};
            exp = {8'hc3, idx, 8'h96, ~idx};
            for (int b = 0; b < 4; b++) rdchk(8'h4b + 8'(b), exp[8 * b +: 8]);
            rdchk(8'h49, (t == 0) ? 8'h10 : 8'h0d);
        end
        $display("test bridge_read done");
    endtask
    task automatic t_enable;
        int n;
        n = xfers;
        wr(8'h48, 8'h02);
        rdchk(8'h48, 8'h02);
        rdchk(8'h48, 8'h02);
        chk(32'(xfers), 32'(n));
        wr(8'h48, 8'h03);
        do ahb(1'b0, 8'h48, 8'h00); while (rd[1] !== 1'b0);
        chk(32'(xfers), 32'(n + 1));
        $display("test enable done");
    endtask
    task automatic t_bridge_write;
        int n;
        wr(8'h48, 8'h0d);
        wr(8'h49, 8'h05);
        wr(8'h4a, 8'h00);
        for (int b = 0; b < 4; b++) wr(8'h4b + 8'(b), 8'(8'h11 * (b + 1)));
        wr(8'h4a, 8'h00);
        chk(far.pmem[8'h45], 32'h44332211);
        rdchk(8'h49, 8'h06);
        n = xfers;
        wr(8'h48, 8'h11);
        wr(8'h4e, 8'h99);
        wr(8'h4a, 8'h00);
        chk(32'(xfers), 32'(n));
        $display("test bridge_write done");
    endtask
    initial begin
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        wait_cycles = 4'h0;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_reset_map();
        t_analog();
        t_bridge_read();
        t_enable();
        t_bridge_write();
        conclude();
    end
endmodule

// ---- rtl/irab_bridge.sv ----
// Indirect register access bridge: AHB-Lite slave, analog indirect port and APB master
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
module irab_bridge (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [2:0] analog_target_select_out,
    output logic [7:0] indirect_offset_out,
    output logic [7:0] indirect_data_value_out,
    output logic ana_req_out,
    output logic ana_write_out,
    input wire logic ana_ack_in,
    input wire logic [7:0] ana_rdata_in,
    output logic [1:0] bridge_target_out,
    output logic psel_out,
    output logic penable_out,
    output logic pwrite_out,
    output logic [15:0] paddr_out,
    output logic [31:0] pwdata_out,
    input wire logic [31:0] prdata_in,
    input wire logic pready_in
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        irab_pkg::irab_ahb_e ahb_st;
        logic acc_write;
        logic acc_ok;
        logic [7:0] acc_idx;
        logic hready;
        logic hresp;
        logic [31:0] hrdata;
        logic [7:0] ana_ctl;
        logic [7:0] ana_off;
        logic [7:0] ana_data;
        logic ana_req;
        logic ana_we;
        logic [7:0] br_ctl;
        logic [15:0] br_addr;
        logic [31:0] br_data;
        irab_pkg::irab_apb_e apb_st;
        logic psel;
        logic penable;
        logic pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
    } irab_state_s;

    logic [1:0] rst_sync_ff;
    logic rst_b;
    irab_state_s state_ff;
    irab_state_s nxt_state;

    function automatic logic ana_target_ok(input logic [7:0] ctl);
        logic [2:0] sel;
        sel = ctl[irab_pkg::ANA_SEL_MSB:irab_pkg::ANA_SEL_LSB];
        return (sel == irab_pkg::ANA_TGT_VIDEO) || (sel == irab_pkg::ANA_TGT_LINK);
    endfunction

    function automatic logic is_bridge_idx(input logic [7:0] idx);
        return (idx >= irab_pkg::IDX_BR_CTL) && (idx <= irab_pkg::IDX_BR_DATA3);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Reset release

    // Async assert, sync release so no flop leaves reset on a ragged edge
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    assign rst_b = rst_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic start_read;
        logic ana_dir_read;
        logic [1:0] br_sel;
        nxt_state = state_ff;
        start_read = 1'b0;
        ana_dir_read = state_ff.ana_ctl[irab_pkg::ANA_DIR_BIT];
        br_sel = state_ff.br_ctl[irab_pkg::BR_SEL_MSB:irab_pkg::BR_SEL_LSB];

        // APB master
        case (state_ff.apb_st)
            irab_pkg::APB_IDLE: begin
                if (state_ff.br_ctl[irab_pkg::BR_EN_BIT] && state_ff.br_ctl[irab_pkg::BR_READ_BIT]) begin
                    start_read = 1'b1;
                    nxt_state.psel = 1'b1;
                    nxt_state.pwrite = 1'b0;
                    nxt_state.paddr = state_ff.br_addr;
                    nxt_state.apb_st = irab_pkg::APB_SETUP;
                end
            end
            irab_pkg::APB_SETUP: begin
                nxt_state.penable = 1'b1;
                nxt_state.apb_st = irab_pkg::APB_ACCESS;
            end
            irab_pkg::APB_ACCESS: begin
                if (pready_in) begin
                    nxt_state.psel = 1'b0;
                    nxt_state.penable = 1'b0;
                    if (!state_ff.pwrite) begin
                        nxt_state.br_data = prdata_in;
                        nxt_state.br_ctl[irab_pkg::BR_READ_BIT] = 1'b0;
                    end
                    if (state_ff.br_ctl[irab_pkg::BR_AUTOINC_BIT]) begin
                        nxt_state.br_addr = state_ff.br_addr + ((br_sel == irab_pkg::BR_TGT_VIDEO) ?
                            irab_pkg::BR_INC_VIDEO : irab_pkg::BR_INC_OTHER);
                    end
                    nxt_state.apb_st = irab_pkg::APB_IDLE;
                end
            end
            default: begin
                nxt_state.apb_st = irab_pkg::APB_IDLE;
            end
        endcase

        // AHB-Lite slave; every transfer has at least one wait state so writes land before the next read
        case (state_ff.ahb_st)
            irab_pkg::AHB_IDLE: begin
                if (hsel_in && hready_in && (htrans_in == irab_pkg::HTRANS_NONSEQ)) begin
                    nxt_state.acc_write = hwrite_in;
                    nxt_state.acc_idx = haddr_in[irab_pkg::IDX_MSB:irab_pkg::IDX_LSB];
                    nxt_state.acc_ok = (haddr_in[irab_pkg::DEC_MSB:irab_pkg::DEC_LSB] == 22'h0) &&
                        (hsize_in == irab_pkg::HSIZE_WORD);
                    nxt_state.hready = 1'b0;
                    nxt_state.ahb_st = irab_pkg::AHB_DATA;
                end
            end
            irab_pkg::AHB_DATA: begin
                nxt_state.hready = 1'b1;
                nxt_state.ahb_st = irab_pkg::AHB_IDLE;
                if (state_ff.acc_write && is_bridge_idx(state_ff.acc_idx) &&
                    ((state_ff.apb_st != irab_pkg::APB_IDLE) || start_read)) begin
                    // Bridge registers are frozen while a bus transfer runs
                    nxt_state.hready = 1'b0;
                    nxt_state.ahb_st = irab_pkg::AHB_DATA;
                end else if (state_ff.acc_write) begin
                    if (state_ff.acc_ok) begin
                        case (state_ff.acc_idx)
                            irab_pkg::IDX_ANA_CTL: nxt_state.ana_ctl = hwdata_in[7:0] & irab_pkg::ANA_CTL_MASK;
                            irab_pkg::IDX_ANA_OFF: nxt_state.ana_off = hwdata_in[7:0];
                            irab_pkg::IDX_ANA_DATA: begin
                                nxt_state.ana_data = hwdata_in[7:0];
                                if (!ana_dir_read && ana_target_ok(state_ff.ana_ctl)) begin
                                    nxt_state.ana_req = 1'b1;
                                    nxt_state.ana_we = 1'b1;
                                    nxt_state.hready = 1'b0;
                                    nxt_state.ahb_st = irab_pkg::AHB_ANA;
                                end
                            end
                            irab_pkg::IDX_BR_CTL: nxt_state.br_ctl = hwdata_in[7:0] & irab_pkg::BR_CTL_MASK;
                            irab_pkg::IDX_BR_ADDR_LO: nxt_state.br_addr[7:0] = hwdata_in[7:0];
                            irab_pkg::IDX_BR_ADDR_HI: nxt_state.br_addr[15:8] = hwdata_in[7:0];
                            irab_pkg::IDX_BR_DATA0: nxt_state.br_data[7:0] = hwdata_in[7:0];
                            irab_pkg::IDX_BR_DATA1: nxt_state.br_data[15:8] = hwdata_in[7:0];
                            irab_pkg::IDX_BR_DATA2: nxt_state.br_data[23:16] = hwdata_in[7:0];
                            irab_pkg::IDX_BR_DATA3: begin
                                nxt_state.br_data[31:24] = hwdata_in[7:0];
                                if (state_ff.br_ctl[irab_pkg::BR_EN_BIT] && !state_ff.br_ctl[irab_pkg::BR_READ_BIT] &&
                                    (br_sel != irab_pkg::BR_TGT_CFG) && (br_sel != irab_pkg::BR_TGT_DIEID)) begin
                                    nxt_state.psel = 1'b1;
                                    nxt_state.pwrite = 1'b1;
                                    nxt_state.paddr = state_ff.br_addr;
                                    nxt_state.pwdata = {hwdata_in[7:0], state_ff.br_data[23:0]};
                                    nxt_state.apb_st = irab_pkg::APB_SETUP;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end else if (state_ff.acc_ok && (state_ff.acc_idx == irab_pkg::IDX_ANA_DATA) &&
                    ana_dir_read && ana_target_ok(state_ff.ana_ctl)) begin
                    nxt_state.ana_req = 1'b1;
                    nxt_state.ana_we = 1'b0;
                    nxt_state.hready = 1'b0;
                    nxt_state.ahb_st = irab_pkg::AHB_ANA;
                end else begin
                    nxt_state.hrdata = 32'h0;
                    if (state_ff.acc_ok) begin
                        case (state_ff.acc_idx)
                            irab_pkg::IDX_ANA_CTL: nxt_state.hrdata[7:0] = state_ff.ana_ctl;
                            irab_pkg::IDX_ANA_OFF: nxt_state.hrdata[7:0] = state_ff.ana_off;
                            irab_pkg::IDX_ANA_DATA: nxt_state.hrdata[7:0] = state_ff.ana_data;
                            irab_pkg::IDX_BR_CTL: nxt_state.hrdata[7:0] = state_ff.br_ctl;
                            irab_pkg::IDX_BR_ADDR_LO: nxt_state.hrdata[7:0] = state_ff.br_addr[7:0];
                            irab_pkg::IDX_BR_ADDR_HI: nxt_state.hrdata[7:0] = state_ff.br_addr[15:8];
                            irab_pkg::IDX_BR_DATA0: nxt_state.hrdata[7:0] = state_ff.br_data[7:0];
                            irab_pkg::IDX_BR_DATA1: nxt_state.hrdata[7:0] = state_ff.br_data[15:8];
                            irab_pkg::IDX_BR_DATA2: nxt_state.hrdata[7:0] = state_ff.br_data[23:16];
                            irab_pkg::IDX_BR_DATA3: nxt_state.hrdata[7:0] = state_ff.br_data[31:24];
                            default: nxt_state.hrdata = 32'h0;
                        endcase
                    end
                end
            end
            irab_pkg::AHB_ANA: begin
                // No timeout: a target that never acknowledges holds the bus
                if (ana_ack_in) begin
                    nxt_state.ana_req = 1'b0;
                    if (!state_ff.ana_we) begin
                        nxt_state.ana_data = ana_rdata_in;
                        nxt_state.hrdata = {24'h0, ana_rdata_in};
                    end
                    if (state_ff.ana_ctl[irab_pkg::ANA_AUTOINC_BIT]) begin
                        nxt_state.ana_off = state_ff.ana_off + irab_pkg::ANA_INC;
                    end
                    nxt_state.hready = 1'b1;
                    nxt_state.ahb_st = irab_pkg::AHB_IDLE;
                end
            end
            default: begin
                nxt_state.hready = 1'b1;
                nxt_state.ahb_st = irab_pkg::AHB_IDLE;
            end
        endcase
        nxt_state.hresp = irab_pkg::HRESP_OKAY;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge core_clk_in or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= '0;
            state_ff.hready <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign hrdata_out = state_ff.hrdata;
    assign hreadyout_out = state_ff.hready;
    assign hresp_out = state_ff.hresp;
    assign analog_target_select_out = state_ff.ana_ctl[irab_pkg::ANA_SEL_MSB:irab_pkg::ANA_SEL_LSB];
    assign indirect_offset_out = state_ff.ana_off;
    assign indirect_data_value_out = state_ff.ana_data;
    assign ana_req_out = state_ff.ana_req;
    assign ana_write_out = state_ff.ana_we;
    assign bridge_target_out = state_ff.br_ctl[irab_pkg::BR_SEL_MSB:irab_pkg::BR_SEL_LSB];
    assign psel_out = state_ff.psel;
    assign penable_out = state_ff.penable;
    assign pwrite_out = state_ff.pwrite;
    assign paddr_out = state_ff.paddr;
    assign pwdata_out = state_ff.pwdata;

endmodule

// ---- rtl/irab_pkg.sv ----
// Constants, types and register map of the indirect register access bridge
package irab_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_ANA_CTL = 8'h40;
    localparam logic [7:0] IDX_ANA_OFF = 8'h41;
    localparam logic [7:0] IDX_ANA_DATA = 8'h42;
    localparam logic [7:0] IDX_BR_CTL = 8'h48;
    localparam logic [7:0] IDX_BR_ADDR_LO = 8'h49;
    localparam logic [7:0] IDX_BR_ADDR_HI = 8'h4a;
    localparam logic [7:0] IDX_BR_DATA0 = 8'h4b;
    localparam logic [7:0] IDX_BR_DATA1 = 8'h4c;
    localparam logic [7:0] IDX_BR_DATA2 = 8'h4d;
    localparam logic [7:0] IDX_BR_DATA3 = 8'h4e;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;
    localparam int DEC_MSB = 31;
    localparam int DEC_LSB = 10;
    // Field layout
    localparam logic [7:0] ANA_CTL_MASK = 8'h1f;
    localparam int ANA_SEL_LSB = 2;
    localparam int ANA_SEL_MSB = 4;
    localparam int ANA_AUTOINC_BIT = 1;
    localparam int ANA_DIR_BIT = 0;
    localparam logic [7:0] BR_CTL_MASK = 8'h1f;
    localparam int BR_SEL_LSB = 3;
    localparam int BR_SEL_MSB = 4;
    localparam int BR_AUTOINC_BIT = 2;
    localparam int BR_READ_BIT = 1;
    localparam int BR_EN_BIT = 0;
    // Target codes
    localparam logic [2:0] ANA_TGT_OFF = 3'h0;
    localparam logic [2:0] ANA_TGT_VIDEO = 3'h4;
    localparam logic [2:0] ANA_TGT_LINK = 3'h5;
    localparam logic [1:0] BR_TGT_VIDEO = 2'h0;
    localparam logic [1:0] BR_TGT_EDID = 2'h1;
    localparam logic [1:0] BR_TGT_CFG = 2'h2;
    localparam logic [1:0] BR_TGT_DIEID = 2'h3;
    // Increments and reset values
    localparam logic [7:0] ANA_INC = 8'h01;
    localparam logic [15:0] BR_INC_VIDEO = 16'h0004;
    localparam logic [15:0] BR_INC_OTHER = 16'h0001;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // Bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;
    typedef enum logic [1:0] {AHB_IDLE, AHB_DATA, AHB_ANA} irab_ahb_e;
    typedef enum logic [1:0] {APB_IDLE, APB_SETUP, APB_ACCESS} irab_apb_e;
endpackage
